// [src/ptimer_defines.svh]
// offsets, field positions, reset values and widths of the periodic timer
`ifndef PTIMER_DEFINES_SVH
`define PTIMER_DEFINES_SVH
`define ADDR_W            5
`define OFS_CTRL0_U0      5'h00
`define OFS_CTRL1_U0      5'h01
`define OFS_CNT_L_U0      5'h02
`define OFS_CNT_H_U0      5'h03
`define OFS_CMPA_L_U0     5'h04
`define OFS_CMPA_H_U0     5'h05
`define OFS_CMPB_L_U0     5'h06
`define OFS_CMPB_H_U0     5'h07
`define OFS_PER_L_U0      5'h08
`define OFS_PER_H_U0      5'h09
`define OFS_FLAGS_U0      5'h0A
`define OFS_CTRL0_U1      5'h10
`define OFS_CTRL1_U1      5'h11
`define OFS_CNT_L_U1      5'h12
`define OFS_CNT_H_U1      5'h13
`define OFS_CMPA_L_U1     5'h14
`define OFS_CMPA_H_U1     5'h15
`define OFS_CMPB_L_U1     5'h16
`define OFS_CMPB_H_U1     5'h17
`define OFS_PER_L_U1      5'h18
`define OFS_PER_H_U1      5'h19
`define OFS_FLAGS_U1      5'h1A
`define UNIT_SEL_BIT      4
`define CTRL0_RUN_BIT     3
`define CTRL1_MODE_MSB    7
`define CTRL1_MODE_LSB    6
`define CTRL1_PIN_MSB     5
`define CTRL1_PIN_LSB     4
`define CTRL1_INIT_BIT    3
`define CTRL1_INV_BIT     2
`define CTRL1_CLR_BIT     0
`define FLAG_A_BIT        0
`define FLAG_P_BIT        1
`define REG_RESET         8'h00
`define UNIT0_WIDTH       16
`define UNIT1_WIDTH       10
`endif

// [src/ptimer_pkg.sv]
// types shared by the periodic timer files
package ptimer_pkg;
	typedef enum logic [1:0] {
		MODE_COMPARE = 2'h0,
		MODE_CAPTURE = 2'h1,
		MODE_PWM     = 2'h2,
		MODE_TIMER   = 2'h3
	} mode_t;
	typedef enum logic [1:0] {
		PIN_NONE   = 2'h0,
		PIN_LOW    = 2'h1,
		PIN_HIGH   = 2'h2,
		PIN_TOGGLE = 2'h3
	} pin_act_t;
	typedef struct packed {
		logic     run;
		mode_t    mode;
		pin_act_t pin_act;
		logic     init_lvl;
		logic     invert;
		logic     clr_sel;
	} unit_cfg_t;
	typedef struct packed {
		logic flag_a;
		logic flag_p;
		logic pin;
	} unit_evt_t;
endpackage

// [src/ptimer_top.sv]
// two periodic timer units with their byte register file
// Operation
// - mode field 00 selects compare match output mode.
// - clear-select low: period match or zero-period overflow clears; A and P flags.
// - clear-select high: compare A match clears; only A flag raised.
// - compare A zero never matches; counter wraps at maximum, no A flag.
// - compare mode pin changes only on compare A match or run rising, never on period.
// - pin action sets high, low, toggles, or does nothing on A match.
// - run bit rising loads pin with the initial level bit.
// - mode 11 counts and flags like compare mode but leaves pin unused.
// - PWM mode ignores clear-select; period sets frequency, A sets duty.
// - PWM mode raises separate A and period match flags.
// - PWM initial level bit picks active level; action passes, forces or holds pin.
// - invert bit inverts the output waveform.
// - unit 0 holds 16-bit A, B, period split in readable bytes.
// - unit 1 holds 10-bit values; high byte bits 7..2 read zero.
// - counter clears on overflow, A match or period match per settings.
// - run rising zeroes counter; run falling freezes its value.
// - PWM period match clears counter; compare A sets duty.
// - duty at or above period keeps PWM output active.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "ptimer_defines.svh"
module ptimer_top #(
	parameter int W0 = `UNIT0_WIDTH,
	parameter int W1 = `UNIT1_WIDTH
) (
	// clock and reset
	input  wire logic               core_clk_in,
	input  wire logic               arst_n_in,
	// register port
	input  wire logic [`ADDR_W-1:0] reg_addr_in,
	input  wire logic [7:0]         reg_wdata_in,
	input  wire logic               reg_wr_in,
	input  wire logic               reg_rd_in,
	output logic [7:0]              reg_rdata_out,
	// timer pins
	output logic                    pin0_out,
	output logic                    pin1_out
);
	typedef logic [7:0] byte_t;
	byte_t ctrl0_ff [2];
	byte_t ctrl1_ff [2];
	byte_t nxt_ctrl0 [2];
	byte_t nxt_ctrl1 [2];
	logic [15:0] cmpa_ff [2];
	logic [15:0] cmpb_ff [2];
	logic [15:0] per_ff [2];
	logic [15:0] nxt_cmpa [2];
	logic [15:0] nxt_cmpb [2];
	logic [15:0] nxt_per [2];
	logic [1:0]  flags_ff [2];
	logic [1:0]  nxt_flags [2];
	logic [15:0] mask [2];
	logic [15:0] cnt [2];
	logic [W0-1:0] cnt0;
	logic [W1-1:0] cnt1;
	ptimer_pkg::unit_cfg_t cfg [2];
	ptimer_pkg::unit_evt_t evt0;
	ptimer_pkg::unit_evt_t evt1;
	logic [1:0]  evt_fl [2];
	byte_t       nxt_rdata;
	logic        u;
	logic [3:0]  sub;

	assign mask[0] = 16'hFFFF;
	assign mask[1] = 16'h03FF;
	assign cnt[0]  = cnt0;
	assign cnt[1]  = {6'h00, cnt1};
	assign evt_fl[0] = {evt0.flag_p, evt0.flag_a};
	assign evt_fl[1] = {evt1.flag_p, evt1.flag_a};

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			cfg[i].run      = ctrl0_ff[i][`CTRL0_RUN_BIT];
			cfg[i].mode     = ptimer_pkg::mode_t'(ctrl1_ff[i][`CTRL1_MODE_MSB:`CTRL1_MODE_LSB]);
			cfg[i].pin_act  = ptimer_pkg::pin_act_t'(ctrl1_ff[i][`CTRL1_PIN_MSB:`CTRL1_PIN_LSB]);
			cfg[i].init_lvl = ctrl1_ff[i][`CTRL1_INIT_BIT];
			cfg[i].invert   = ctrl1_ff[i][`CTRL1_INV_BIT];
			cfg[i].clr_sel  = ctrl1_ff[i][`CTRL1_CLR_BIT];
		end
	end

	ptimer_unit #(.W(W0)) u_unit0 (
		.core_clk_in (core_clk_in),
		.arst_n_in   (arst_n_in),
		.cfg_in      (cfg[0]),
		.cmp_a_in    (cmpa_ff[0][W0-1:0]),
		.per_in      (per_ff[0][W0-1:0]),
		.count_out   (cnt0),
		.evt_out     (evt0)
	);

	ptimer_unit #(.W(W1)) u_unit1 (
		.core_clk_in (core_clk_in),
		.arst_n_in   (arst_n_in),
		.cfg_in      (cfg[1]),
		.cmp_a_in    (cmpa_ff[1][W1-1:0]),
		.per_in      (per_ff[1][W1-1:0]),
		.count_out   (cnt1),
		.evt_out     (evt1)
	);

	// register writes; hardware flag set wins over a software clear
	always_comb begin
		u   = reg_addr_in[`UNIT_SEL_BIT];
		sub = reg_addr_in[3:0];
		for (int i = 0; i < 2; i++) begin
			nxt_ctrl0[i] = ctrl0_ff[i];
			nxt_ctrl1[i] = ctrl1_ff[i];
			nxt_cmpa[i]  = cmpa_ff[i];
			nxt_cmpb[i]  = cmpb_ff[i];
			nxt_per[i]   = per_ff[i];
			nxt_flags[i] = flags_ff[i];
			if (reg_wr_in && (u == i[0])) begin
				unique case ({1'b0, sub})
					`OFS_CTRL0_U0:  nxt_ctrl0[i] = reg_wdata_in & 8'h08;
					`OFS_CTRL1_U0:  nxt_ctrl1[i] = reg_wdata_in;
					`OFS_CMPA_L_U0: nxt_cmpa[i][7:0] = reg_wdata_in;
					`OFS_CMPA_H_U0: nxt_cmpa[i][15:8] = reg_wdata_in & mask[i][15:8];
					`OFS_CMPB_L_U0: nxt_cmpb[i][7:0] = reg_wdata_in;
					`OFS_CMPB_H_U0: nxt_cmpb[i][15:8] = reg_wdata_in & mask[i][15:8];
					`OFS_PER_L_U0:  nxt_per[i][7:0] = reg_wdata_in;
					`OFS_PER_H_U0:  nxt_per[i][15:8] = reg_wdata_in & mask[i][15:8];
					`OFS_FLAGS_U0:  nxt_flags[i] = flags_ff[i] & ~reg_wdata_in[1:0];
					default: ;
				endcase
			end
			nxt_flags[i] = nxt_flags[i] | evt_fl[i];
		end
		nxt_rdata = 8'h00;
		if (reg_rd_in) begin
			unique case ({1'b0, sub})
				`OFS_CTRL0_U0:  nxt_rdata = ctrl0_ff[u];
				`OFS_CTRL1_U0:  nxt_rdata = ctrl1_ff[u];
				`OFS_CNT_L_U0:  nxt_rdata = cnt[u][7:0];
				`OFS_CNT_H_U0:  nxt_rdata = cnt[u][15:8];
				`OFS_CMPA_L_U0: nxt_rdata = cmpa_ff[u][7:0];
				`OFS_CMPA_H_U0: nxt_rdata = cmpa_ff[u][15:8];
				`OFS_CMPB_L_U0: nxt_rdata = cmpb_ff[u][7:0];
				`OFS_CMPB_H_U0: nxt_rdata = cmpb_ff[u][15:8];
				`OFS_PER_L_U0:  nxt_rdata = per_ff[u][7:0];
				`OFS_PER_H_U0:  nxt_rdata = per_ff[u][15:8];
				`OFS_FLAGS_U0:  nxt_rdata = {6'h00, flags_ff[u]};
				default:        nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			for (int i = 0; i < 2; i++) begin
				ctrl0_ff[i] <= `REG_RESET;
				ctrl1_ff[i] <= `REG_RESET;
				cmpa_ff[i]  <= 16'h0000;
				cmpb_ff[i]  <= 16'h0000;
				per_ff[i]   <= 16'h0000;
				flags_ff[i] <= 2'h0;
			end
			reg_rdata_out <= 8'h00;
			pin0_out      <= 1'b0;
			pin1_out      <= 1'b0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				ctrl0_ff[i] <= nxt_ctrl0[i];
				ctrl1_ff[i] <= nxt_ctrl1[i];
				cmpa_ff[i]  <= nxt_cmpa[i];
				cmpb_ff[i]  <= nxt_cmpb[i];
				per_ff[i]   <= nxt_per[i];
				flags_ff[i] <= nxt_flags[i];
			end
			reg_rdata_out <= nxt_rdata;
			// one more stage keeps outputs on flip-flops
			pin0_out      <= evt0.pin;
			pin1_out      <= evt1.pin;
		end
	end
endmodule

// [src/ptimer_unit.sv]
// one timer unit: counter, comparators, match flags and output pin
`timescale 1ns/1ps
`include "ptimer_defines.svh"
module ptimer_unit #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic                  core_clk_in,
	input  wire logic                  arst_n_in,
	// configuration
	input  wire ptimer_pkg::unit_cfg_t cfg_in,
	input  wire logic [W-1:0]          cmp_a_in,
	input  wire logic [W-1:0]          per_in,
	// state
	output logic [W-1:0]               count_out,
	output ptimer_pkg::unit_evt_t      evt_out
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;
	logic         run_d_ff;
	logic         pin_ff;
	logic         nxt_pin;
	logic         pwm_ff;
	logic         nxt_pwm;
	logic         hit_a;
	logic         hit_p;
	logic         wrap;
	logic         clr;
	logic         fa;
	logic         fp;
	logic         pwm_mode;
	logic         rise;
	logic         act;
	logic [W-1:0] cnt_inc;

	always_comb begin
		cnt_inc  = cnt_ff + 1'b1;
		pwm_mode = (cfg_in.mode == ptimer_pkg::MODE_PWM);
		rise     = cfg_in.run & ~run_d_ff;
		hit_a    = cfg_in.run & (cmp_a_in != '0) & (cnt_inc == cmp_a_in);
		hit_p    = cfg_in.run & (per_in != '0) & (cnt_inc == per_in);
		wrap     = cfg_in.run & (per_in == '0) & (cnt_ff == '1);
		fa = 1'b0;
		fp = 1'b0;
		clr = 1'b0;
		if (pwm_mode || !cfg_in.clr_sel) begin
			// period match or full-range wrap when period is zero
			clr = hit_p | wrap;
			fa  = hit_a;
			fp  = hit_p;
		end else begin
			// zero compare A never matches, so the counter rolls over at max
			clr = hit_a | (cfg_in.run & (cmp_a_in == '0) & (cnt_ff == '1));
			fa  = hit_a;
		end
		nxt_cnt = cnt_ff;
		if (rise) begin
			nxt_cnt = '0;
		end else if (cfg_in.run) begin
			nxt_cnt = clr ? '0 : cnt_inc;
		end
		// pwm active from counter zero until duty match; duty >= period stays active
		nxt_pwm = pwm_ff;
		if (rise || clr) begin
			nxt_pwm = 1'b1;
		end else if (hit_a && ((cmp_a_in < per_in) || (per_in == '0))) begin
			nxt_pwm = 1'b0;
		end
		act = cfg_in.init_lvl ? nxt_pwm : ~nxt_pwm;
		nxt_pin = pin_ff;
		if (rise) begin
			nxt_pin = cfg_in.init_lvl;
		end else if (pwm_mode) begin
			unique case (cfg_in.pin_act)
				ptimer_pkg::PIN_NONE:   nxt_pin = ~cfg_in.init_lvl;
				ptimer_pkg::PIN_LOW:    nxt_pin = cfg_in.init_lvl;
				ptimer_pkg::PIN_HIGH:   nxt_pin = act;
				ptimer_pkg::PIN_TOGGLE: nxt_pin = pin_ff;
			endcase
		end else if (cfg_in.mode == ptimer_pkg::MODE_COMPARE && fa) begin
			unique case (cfg_in.pin_act)
				ptimer_pkg::PIN_NONE:   nxt_pin = pin_ff;
				ptimer_pkg::PIN_LOW:    nxt_pin = 1'b0;
				ptimer_pkg::PIN_HIGH:   nxt_pin = 1'b1;
				ptimer_pkg::PIN_TOGGLE: nxt_pin = ~pin_ff;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_ff   <= '0;
			run_d_ff <= 1'b0;
			pin_ff   <= 1'b0;
			pwm_ff   <= 1'b0;
			evt_out  <= '0;
		end else begin
			cnt_ff         <= nxt_cnt;
			run_d_ff       <= cfg_in.run;
			pin_ff         <= nxt_pin;
			pwm_ff         <= nxt_pwm;
			evt_out.flag_a <= fa;
			evt_out.flag_p <= fp;
			// timer/counter mode leaves the pin at rest; invert only outside it
			evt_out.pin    <= (cfg_in.mode == ptimer_pkg::MODE_TIMER) ? 1'b0 :
				(nxt_pin ^ cfg_in.invert);
		end
	end

	assign count_out = cnt_ff;
endmodule

// [testbench/periodic_timer_compare_pwm_test.sv]
// self-checking bench for the two-unit periodic timer
`timescale 1ns/1ps
module periodic_timer_compare_pwm_test;
	logic        core_clk_in = 1'b0;
	logic        arst_n_in = 1'b0;
	logic [4:0]  reg_addr_in = 5'h00;
	logic [7:0]  reg_wdata_in = 8'h00;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic        win = 1'b0;
	logic [7:0]  reg_rdata_out, high0, rise0, high1, rise1;
	logic        pin0_out, pin1_out;
	int          error_cnt = 0;
	int          total_checks = 0;
	// unit, ctrl1, compare A, period, flags, rises and high cycles per 100
	logic [71:0] tbl [12] = '{
		72'h00_30_0003_0005_03_0A_32, 72'h00_31_0005_0002_01_0A_32,
		72'h00_20_0003_0005_03_00_64, 72'h00_18_0003_0005_03_00_00,
		72'h00_F0_0003_0005_03_00_00, 72'h10_31_0000_0000_00_00_00,
		72'h00_A9_0004_000A_03_0A_28, 72'h00_AD_0004_000A_03_0A_3C,
		72'h00_A1_0004_000A_03_0A_3C, 72'h00_A8_000C_000A_02_00_64,
		72'h00_98_0004_000A_03_00_64, 72'h00_88_0004_000A_03_00_00};
	ptimer_top u_ptimer_top (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .pin0_out(pin0_out),
		.pin1_out(pin1_out));
	pin_watch u_pin_watch0 (.core_clk_in(core_clk_in), .win_in(win), .pin_in(pin0_out),
		.high_out(high0), .rise_out(rise0));
	pin_watch u_pin_watch1 (.core_clk_in(core_clk_in), .win_in(win), .pin_in(pin1_out),
		.high_out(high1), .rise_out(rise1));
	initial begin
		forever #2 core_clk_in = ~core_clk_in;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		reg_wr_in    <= 1'b1;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		#1 chk(reg_rdata_out, exp);
	endtask
	// stop first: mode and pin action are only safe to change while stopped
	task automatic cfg(input logic [4:0] b, input logic [7:0] c1,
		input logic [15:0] a, input logic [15:0] p);
		wr(b, 8'h00);
		wr(b | 5'h01, c1);
		wr(b | 5'h04, a[7:0]);
		wr(b | 5'h05, a[15:8]);
		wr(b | 5'h08, p[7:0]);
		wr(b | 5'h09, p[15:8]);
		wr(b | 5'h0A, 8'h03);
		wr(b, 8'h08);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#200000;
		error_cnt++;
		$display("watchdog expired");
		tally_and_finish();
	end
	initial begin
		repeat (5) @(posedge core_clk_in);
		arst_n_in <= 1'b1;
		for (int u = 0; u < 2; u++) begin
			for (int i = 4; i < 10; i++) begin
				logic [4:0] a;
				logic [7:0] d;
				a = {u[0], i[3:0]};
				d = {3'h7, a};
				rd(a, 8'h00);
				wr(a, d);
				rd(a, (u == 1 && i[0]) ? (d & 8'h03) : d);
			end
		end
		wr(5'h0B, 8'hFF);
		rd(5'h0B, 8'h00);
		$display("register test done");
		foreach (tbl[k]) begin
			cfg(tbl[k][68:64], tbl[k][63:56], tbl[k][55:40], tbl[k][39:24]);
			repeat (1100) @(posedge core_clk_in);
			win <= 1'b1;
			repeat (100) @(posedge core_clk_in);
			win <= 1'b0;
			#1 chk(tbl[k][68] ? high1 : high0, tbl[k][7:0]);
			chk(tbl[k][68] ? rise1 : rise0, tbl[k][15:8]);
			rd(tbl[k][68:64] | 5'h0A, tbl[k][23:16]);
			$display("timer test %0d done", k);
		end
		// stop, restart and stop again: one counted edge between the two run writes
		wr(5'h00, 8'h00);
		wr(5'h00, 8'h08);
		wr(5'h00, 8'h00);
		rd(5'h02, 8'h01);
		rd(5'h02, 8'h01);
		rd(5'h03, 8'h00);
		$display("run restart test done");
		tally_and_finish();
	end
endmodule
bind ptimer_top ptimer_top_props #(.W0(W0), .W1(W1)) u_ptimer_top_props (
	.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .pin0_out(pin0_out), .pin1_out(pin1_out));

// [testbench/pin_watch.sv]
// load on a timer pin: counts high samples and rising edges inside a window
`timescale 1ns/1ps
module pin_watch (
	// clock and window
	input  wire logic core_clk_in,
	input  wire logic win_in,
	// pin and counts
	input  wire logic pin_in,
	output logic [7:0] high_out,
	output logic [7:0] rise_out
);
	logic last_ff;
	logic wl_ff;
	// counts restart on window opening so stale totals never leak into the next test
	always_ff @(posedge core_clk_in) begin
		last_ff <= pin_in;
		wl_ff   <= win_in;
		if (win_in) begin
			high_out <= (wl_ff ? high_out : 8'h00) + {7'h00, pin_in};
			rise_out <= (wl_ff ? rise_out : 8'h00) + {7'h00, pin_in & ~last_ff};
		end
	end
endmodule

// [testbench/ptimer_top_props.sv]
// concurrent checks on the timer register port and output pins
`timescale 1ns/1ps
module ptimer_top_props #(
	parameter int W0 = 16,
	parameter int W1 = 10
) (
	// clock and reset
	input wire logic       core_clk_in,
	input wire logic       arst_n_in,
	// register port and pins
	input wire logic [4:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic       pin0_out,
	input wire logic       pin1_out
);
	// shadow of unit 0 control; pin checks wait out the two-edge pin latency
	logic [7:0] ctl_ff;
	logic       run_ff;
	logic [2:0] age_ff;
	logic       rd_hi_ff;
	logic       rd_bad_ff;
	wire        ctl_wr = reg_wr_in && reg_addr_in[4:1] == 4'h0;
	wire        settled = age_ff == 3'h7;
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctl_ff    <= 8'h00;
			run_ff    <= 1'b0;
			age_ff    <= 3'h0;
			rd_hi_ff  <= 1'b0;
			rd_bad_ff <= 1'b0;
		end else begin
			if (ctl_wr && reg_addr_in[0]) begin
				ctl_ff <= reg_wdata_in;
			end
			if (ctl_wr && !reg_addr_in[0]) begin
				run_ff <= reg_wdata_in[3];
			end
			age_ff    <= ctl_wr ? 3'h0 : age_ff + {2'h0, !settled};
			rd_hi_ff  <= reg_rd_in && reg_addr_in[4] && reg_addr_in[0]
				&& reg_addr_in[3:1] inside {3'h1, 3'h2, 3'h3, 3'h4};
			rd_bad_ff <= reg_rd_in && reg_addr_in[3:0] > 4'hA;
		end
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);
	a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
		else $error("read data outside its slot");
	a_hi_bits_zero: assert property (rd_hi_ff |-> reg_rdata_out[7:2] == 6'h00)
		else $error("unit 1 high byte upper bits set");
	a_unmapped_zero: assert property (rd_bad_ff |-> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	a_reset_quiet: assert property ($rose(arst_n_in) |-> !pin0_out && !pin1_out)
		else $error("pins not low after reset");
	a_run_init: assert property (ctl_wr && !reg_addr_in[0] && reg_wdata_in[3] && !run_ff
		&& ctl_ff[7:6] == 2'h0 |-> ##[1:3] pin0_out == (ctl_ff[3] ^ ctl_ff[2]))
		else $error("run start did not load initial level");
	a_none_holds: assert property (settled && ctl_ff[7:4] == 4'h0 |-> $stable(pin0_out))
		else $error("pin moved with no action");
	a_high_no_fall: assert property (settled && ctl_ff[7:4] == 4'h2 && !ctl_ff[2]
		|-> !$fell(pin0_out))
		else $error("pin fell in set-high action");
	a_low_no_rise: assert property (settled && ctl_ff[7:4] == 4'h1 && !ctl_ff[2]
		|-> !$rose(pin0_out))
		else $error("pin rose in set-low action");
	a_timer_no_pin: assert property (settled && ctl_ff[7:6] == 2'h3 |-> !pin0_out)
		else $error("pin driven in timer mode");
	a_pwm_forced: assert property (settled && ctl_ff[7:5] == 3'h4
		|-> pin0_out == ((ctl_ff[4] ~^ ctl_ff[3]) ^ ctl_ff[2]))
		else $error("forced pwm level wrong");
	c_run_start: cover property (ctl_wr && !reg_addr_in[0] && reg_wdata_in[3] && !run_ff);
	c_pwm_forced: cover property (settled && ctl_ff[7:5] == 3'h4);
	c_hi_read: cover property (rd_hi_ff);
endmodule
